// [rtl/local_peripheral_bus_master.sv]
`timescale 1ns/1ps
module local_peripheral_bus_master (
   input  wire logic                      sys_clk,
   input  wire logic                      reset,
   input  wire logic                      req_valid,
   input  wire logic                      req_read,
   input  wire logic                      req_sel,
   input  wire logic [lpb_pkg::ADDR_W-1:0] req_addr,
   input  wire logic [lpb_pkg::DATA_W-1:0] req_wdata,
   input  wire logic                      handshake_mode,
   output logic                           req_ready,
   output logic                           done,
   output logic      [lpb_pkg::DATA_W-1:0] rdata,
   output logic                           irq,
   output logic      [lpb_pkg::ADDR_W-1:0] periph_addr,
   output logic                           periph_read_not_write,
   output logic                           periph_select_1_n,
   output logic                           periph_select_2_n,
   input  wire logic                      periph_ack,
   input  wire logic                      periph_irq_n,
   input  wire logic [lpb_pkg::DATA_W-1:0] periph_data_in,
   output logic      [lpb_pkg::DATA_W-1:0] periph_data_out,
   output logic                           periph_data_oe
);
   import lpb_pkg::*;

   typedef struct packed {
      lpb_state_t          state;
      logic [3:0]          cnt;
      logic                hs;
      logic [ADDR_W-1:0]   addr;
      logic                rnw;
      logic                sel1_n;
      logic                sel2_n;
      logic [DATA_W-1:0]   wdata;
      logic                oe;
      logic [DATA_W-1:0]   rdata;
      logic                done;
      logic                ready;
      logic                irq;
   } master_t;

   master_t m_r;
   master_t m_nxt;

   logic [SYNC_BITS-1:0] sync_out;
   logic [DATA_W-1:0]    data_s;
   logic                 ack_s;
   logic                 irq_n_s;

   // pins arrive from outside, two flops before any logic looks
   pin_sync #(
      .WIDTH   (SYNC_BITS),
      .RST_VAL (SYNC_RESET)
   ) u_sync (
      .sys_clk (sys_clk),
      .reset   (reset),
      .din     ({periph_irq_n, periph_ack, periph_data_in}),
      .dout    (sync_out)
   );

   assign data_s  = sync_out[DATA_W-1:0];
   assign ack_s   = sync_out[SYNC_ACK_BIT];
   assign irq_n_s = sync_out[SYNC_IRQ_BIT];

   // fixed mode counts only and ignores ack; handshake also waits until the
   // synchroniser has flushed what the ack pin showed before this access
   function automatic logic finished(input logic       hs,
                                     input logic [3:0] cnt,
                                     input logic       ack);
      logic ack_fresh;
      ack_fresh = (cnt >= 4'(SYNC_STAGES));
      if (hs) begin
         finished = ack && ack_fresh;
      end else begin
         finished = (cnt == FIXED_LAST);
      end
   endfunction : finished

   // saturates so a long handshake wait cannot wrap back under the guard
   function automatic logic [3:0] count_up(input logic [3:0] cnt);
      if (cnt == 4'hf) begin
         count_up = cnt;
      end else begin
         count_up = cnt + 4'h1;
      end
   endfunction : count_up

   // low-active pair {second, first}: never both low, both high at rest
   function automatic logic [1:0] select_pair(input logic active,
                                              input logic second);
      logic [1:0] pair;
      pair = 2'b11;
      if (active) begin
         pair[0] = second;
         pair[1] = ~second;
      end
      select_pair = pair;
   endfunction : select_pair

   // bus released, nothing pending: used by reset and illegal-state recovery
   function automatic master_t idle_state();
      master_t st;
      st.state  = ST_IDLE;
      st.cnt    = CNT_RESET;
      st.hs     = 1'b0;
      st.addr   = ADDR_RESET;
      st.rnw    = 1'b1;
      st.sel1_n = 1'b1;
      st.sel2_n = 1'b1;
      st.wdata  = DATA_RESET;
      st.oe     = 1'b0;
      st.rdata  = DATA_RESET;
      st.done   = 1'b0;
      st.ready  = 1'b0;
      st.irq    = 1'b0;
      idle_state = st;
   endfunction : idle_state

   // all request fields latched together so they stand the whole access
   function automatic master_t load_request(input master_t             cur,
                                            input logic                rd,
                                            input logic                second,
                                            input logic                hs,
                                            input logic [ADDR_W-1:0]   addr,
                                            input logic [DATA_W-1:0]   wdata);
      master_t st;
      st       = cur;
      st.ready = 1'b0;
      st.state = ST_ACCESS;
      st.cnt   = CNT_RESET;
      // mode taken once so it cannot change mid transfer
      st.hs    = hs;
      st.addr  = addr;
      st.rnw   = rd;
      st.wdata = wdata;
      st.oe    = ~rd;
      {st.sel2_n, st.sel1_n} = select_pair(1'b1, second);
      load_request = st;
   endfunction : load_request

   // data released one cycle after the select rises, so the slave's hold
   // window never meets our drive; direction rests at read
   function automatic master_t release_bus(input master_t cur);
      master_t st;
      st       = cur;
      st.oe    = 1'b0;
      st.rnw   = 1'b1;
      st.ready = 1'b1;
      st.state = ST_IDLE;
      release_bus = st;
   endfunction : release_bus

   // end of access: select up, done pulse, read byte taken in this cycle
   function automatic master_t end_access(input master_t             cur,
                                          input logic [DATA_W-1:0]   rbyte);
      master_t st;
      st = cur;
      if (cur.rnw) begin
         st.rdata = rbyte;
      end
      st.done  = 1'b1;
      {st.sel2_n, st.sel1_n} = select_pair(1'b0, 1'b0);
      st.state = ST_FINISH;
      end_access = st;
   endfunction : end_access

   always_comb begin
      m_nxt      = m_r;
      m_nxt.done = 1'b0;
      case (m_r.state)
         ST_IDLE: begin
            m_nxt.ready = 1'b1;
            if (req_valid && m_r.ready) begin
               m_nxt = load_request(m_nxt, req_read, req_sel, handshake_mode,
                                    req_addr, req_wdata);
            end
         end
         ST_ACCESS: begin
            m_nxt.cnt = count_up(m_r.cnt);
            if (finished(m_r.hs, m_r.cnt, ack_s)) begin
               m_nxt = end_access(m_nxt, data_s);
            end
         end
         ST_FINISH: begin
            m_nxt = release_bus(m_nxt);
         end
         default: begin
            m_nxt = idle_state();
         end
      endcase
      // plain level, follows the synchronised pin
      m_nxt.irq = ~irq_n_s;
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         m_r <= idle_state();
      end else begin
         m_r <= m_nxt;
      end
   end

   assign req_ready             = m_r.ready;
   assign done                  = m_r.done;
   assign rdata                 = m_r.rdata;
   assign irq                   = m_r.irq;
   assign periph_addr           = m_r.addr;
   assign periph_read_not_write = m_r.rnw;
   assign periph_select_1_n     = m_r.sel1_n;
   assign periph_select_2_n     = m_r.sel2_n;
   assign periph_data_out       = m_r.wdata;
   assign periph_data_oe        = m_r.oe;
endmodule : local_peripheral_bus_master

// [include/lpb_pkg.sv]
package lpb_pkg;
   localparam int unsigned ADDR_W        = 12;
   localparam int unsigned DATA_W        = 8;
   localparam int unsigned FIXED_CYCLES  = 8;
   localparam logic [3:0]  FIXED_LAST    = 4'(FIXED_CYCLES - 1);
   localparam logic [3:0]  CNT_RESET     = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;
   localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
   localparam int unsigned SYNC_STAGES   = 2;
   localparam int unsigned SYNC_BITS     = DATA_W + 2;
   localparam int unsigned SYNC_ACK_BIT  = DATA_W;
   localparam int unsigned SYNC_IRQ_BIT  = DATA_W + 1;
   // ack rests inactive low, interrupt rests high, so reset shows no stale ack
   localparam logic [SYNC_BITS-1:0] SYNC_RESET = 10'h200;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ACCESS,
      ST_FINISH
   } lpb_state_t;
endpackage : lpb_pkg

// [rtl/pin_sync.sv]
`timescale 1ns/1ps
module pin_sync #(
   parameter int unsigned            WIDTH    = 1,
   parameter logic [WIDTH-1:0]       RST_VAL  = '0
) (
   input  wire logic             sys_clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_t;

   sync_t s_r;
   sync_t s_nxt;

   always_comb begin
      s_nxt        = s_r;
      s_nxt.meta   = din;
      // first stage only feeds the second
      s_nxt.stable = s_r.meta;
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s_r <= {RST_VAL, RST_VAL};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign dout = s_r.stable;
endmodule : pin_sync

// [dv/lpb_chk.sv]
`timescale 1ns/1ps
module lpb_chk (
   input wire logic sys_clk, reset, req_valid, req_ready, req_read, req_sel, handshake_mode,
   input wire logic done, irq, periph_read_not_write, periph_select_1_n, periph_select_2_n,
   input wire logic periph_ack, periph_irq_n, periph_data_oe,
   input wire logic [11:0] req_addr, periph_addr,
   input wire logic [7:0] rdata, periph_data_in
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   wire t = req_valid && req_ready;
   wire s = !(periph_select_1_n && periph_select_2_n);
   logic hs_r;
   // mode is sampled per transaction
   always_ff @(posedge sys_clk) begin
      if (reset) hs_r <= 1'b0;
      else if (t) hs_r <= handshake_mode;
   end
   AST_ONE_SEL: assert property (periph_select_1_n || periph_select_2_n) else $error("two");
   AST_FIXED: assert property (t && !handshake_mode |=> s[*8] ##1 (done && !s))
      else $error("length");
   AST_ADDR: assert property (t |=> periph_addr == $past(req_addr)) else $error("addr");
   AST_DIR: assert property (t |=> periph_read_not_write == $past(req_read)
      && periph_data_oe != $past(req_read)) else $error("dir");
   AST_SEL: assert property (t |=> periph_select_1_n == $past(req_sel)
      && periph_select_2_n != $past(req_sel)) else $error("sel");
   AST_HOLD: assert property (s && $past(s) |-> $stable(periph_addr)
      && $stable(periph_read_not_write)) else $error("hold");
   AST_WAIT: assert property (hs_r && s && !periph_ack && !$past(periph_ack)
      && !$past(periph_ack, 2) |=> s) else $error("early end");
   AST_RDATA: assert property (done && periph_read_not_write
      |-> rdata == $past(periph_data_in, 3)) else $error("rdata");
   AST_IRQ: assert property (!periph_irq_n [*4] |-> irq) else $error("irq");
   cover property (t && handshake_mode);
   cover property (t && !handshake_mode && req_read);
   cover property (!periph_irq_n ##4 irq);
endmodule : lpb_chk
bind local_peripheral_bus_master lpb_chk i_lpb_chk (.*);

// [dv/periph_model.sv]
`timescale 1ns/1ps
module periph_model (
   input wire logic sys_clk, periph_read_not_write, periph_select_1_n, periph_select_2_n,
   input wire logic [11:0] periph_addr,
   input wire logic [7:0] periph_data_out,
   input wire logic [3:0] ack_dly,
   output logic periph_ack = 0,
   output logic [7:0] periph_data_in = 8'hff,
   output logic [20:0] seen
);
   int n = 0;
   always @(posedge sys_clk) begin
      #1;
      n = periph_select_1_n && periph_select_2_n ? 0 : n + 1;
      periph_ack = n > ack_dly;
      // pulled up once released
      periph_data_in = n > 0 && periph_read_not_write ? periph_addr[7:0] ^ 8'h5a : 8'hff;
      if (n > 0 && !periph_read_not_write) seen = {!periph_select_2_n, periph_addr, periph_data_out};
   end
endmodule : periph_model

// [dv/local_peripheral_bus_master_bench.sv]
`timescale 1ns/1ps
module local_peripheral_bus_master_bench;
   logic sys_clk = 0, reset = 1, req_valid = 0, req_read = 0, req_sel = 0;
   logic handshake_mode = 0, periph_irq_n = 1;
   logic [11:0] req_addr = '0, periph_addr;
   logic [7:0] req_wdata = '0, rdata, periph_data_in, periph_data_out;
   logic [3:0] ack_dly = 4'h2;
   logic req_ready, done, irq, periph_read_not_write, periph_select_1_n, periph_select_2_n;
   logic periph_ack, periph_data_oe;
   logic [20:0] seen;
   logic [31:0] r;
   int num_errors = 0, check_count = 0, seed = 23, k;
   always #12.5 sys_clk = ~sys_clk;
   local_peripheral_bus_master i_local_peripheral_bus_master (.*);
   periph_model i_periph_model (.*);
   task automatic cmp(input logic [20:0] got, exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task automatic finish_test;
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : finish_test
   // edges from the take to done: eight selected cycles in fixed mode; in
   // handshake the model's delay, two sync stages, one edge to register done
   function automatic logic [20:0] exp_cycles(input logic hs, input logic [3:0] dly);
      exp_cycles = hs ? 21'(dly) + 21'd3 : 21'd8;
   endfunction : exp_cycles
   task automatic xfer(input logic rd, sl, hs, input logic [11:0] a, input logic [7:0] d);
      while (req_ready !== 1'b1) @(posedge sys_clk) #1;
      {req_valid, req_read, req_sel, handshake_mode, req_addr, req_wdata} = {1'b1, rd, sl, hs, a, d};
      @(posedge sys_clk) #1;
      req_valid = 0;
      k = 0;
      while (done !== 1'b1 && k < 40) begin
         @(posedge sys_clk) #1;
         k++;
      end
      if (hs) cmp(21'(k), exp_cycles(1'b1, ack_dly));
      else cmp(21'(k), exp_cycles(1'b0, ack_dly));
      if (rd) cmp(rdata, a[7:0] ^ 8'h5a);
      else cmp(seen, {sl, a, d});
   endtask : xfer
   initial begin
      repeat (6) @(posedge sys_clk);
      #1 reset = 0;
      xfer(0, 0, 0, 12'hfff, 8'h80);
      xfer(1, 1, 0, 12'h0a5, 8'h00);
      xfer(1, 0, 1, 12'h800, 8'h01);
      xfer(0, 1, 1, 12'h001, 8'h7f);
      // reset in mid access: selects must let go, master must restart
      ack_dly = 4'hf;
      while (req_ready !== 1'b1) @(posedge sys_clk) #1;
      {req_valid, req_read, req_sel, handshake_mode} = 4'b1011;
      @(posedge sys_clk) #1;
      req_valid = 0;
      repeat (3) @(posedge sys_clk);
      #1 reset = 1;
      repeat (3) @(posedge sys_clk);
      #1 cmp({periph_select_1_n, periph_select_2_n, periph_data_oe, periph_read_not_write, req_ready, done}, 6'b110100);
      reset = 0;
      @(posedge sys_clk);
      #1 cmp({req_ready, periph_select_1_n, periph_select_2_n}, 3'b111);
      repeat (30) begin
         r = $random(seed);
         ack_dly = 4'(r[25:23] % 3'd5 + 3'd2);
         xfer(r[0], r[1], r[2], r[14:3], r[22:15]);
      end
      periph_irq_n = 0;
      repeat (4) @(posedge sys_clk);
      #1 cmp(irq, 1);
      periph_irq_n = 1;
      repeat (4) @(posedge sys_clk);
      #1 cmp(irq, 0);
      finish_test;
   end
   initial begin
      #40us;
      num_errors++;
      finish_test;
   end
endmodule : local_peripheral_bus_master_bench
